// ===== hdl/cspwm_top.sv
// Four compare and standard pulse-width units behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Matching and timing freeze while the system clock sleeps.
// - PWM mode drives a waveform on the output pin, up to 10 bits.
// - Period, duty and resolution come only from period, timer, value and mode registers.
// - Writing mode control to zero releases the output pin.
// - Mode control: mode select 3:0, duty low bits 5:4, enhanced config 7:6 units 0-1.
// - Unimplemented register bits read as zero.
// - The 16-bit value lives in a low byte and a high byte register.
// - High means on; 0% duty is always off, 100% always on.
// - A period is one on plus off cycle; resolution counts its steps.
// - Two alternate pin select registers relocate the unit pins.
// - Compare mode matches value to timebase, sets flag, acts on pin or trigger.
// - At period end: clear count, set pin unless duty zero, latch duty.
// - Duty is value low byte as upper eight bits, duty low bits below.
// - Pin clears when 10-bit time base equals the buffered duty.
module cspwm_top (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [15:0] TIMEBASE,
	input wire logic SLEEP,
	output logic [3:0] PIN_OUT,
	output logic [3:0] PIN_DRIVE,
	output logic [3:0] TRIGGER,
	output logic [3:0] MATCH_FLAG,
	output logic [7:0] ALT_SEL0,
	output logic [7:0] ALT_SEL1
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] mode [0:3], low [0:3], high [0:3];
	logic [7:0] next_mode [0:3], next_low [0:3], next_high [0:3];
	logic [1:0] latch2 [0:3], next_latch2 [0:3];
	logic [3:0] eq_prev, pre, next_eq_prev, next_pre;
	logic [3:0] next_pin, next_drive, next_trig, next_flag;
	logic [7:0] period, tctl, count, next_period, next_tctl, next_count;
	logic [7:0] aw_addr, w_data, next_aw_addr, next_w_data, next_alt0, next_alt1;
	logic [1:0] q, next_q, next_bresp, next_rresp;
	logic aw_held, w_held, w_strb0, next_aw_held, next_w_held, next_w_strb0;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [31:0] next_rdata;
	// ---------------------------------------------------------------
	// Period timer and shared terms
	// ---------------------------------------------------------------
	logic running, pre_tick, period_end, wr_fire, wr_en, rd_fire;
	logic [3:0] pre_lim;
	logic [9:0] tb, tb_next;
	logic [3:0] cmp_event, pwm_on;

	assign running = tctl[cspwm_pkg::TCTL_ON_BIT] & ~SLEEP;
	assign tb = {count, q};
	assign tb_next = tb + 10'h001; // Lets the pin drop as the time base reaches the duty
	assign wr_fire = aw_held & w_held & ~S_AXI_BVALID;
	assign wr_en = wr_fire & w_strb0;
	assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
	assign pre_lim = tctl[1] ? cspwm_pkg::PRE_LIM_16
		: (tctl[0] ? cspwm_pkg::PRE_LIM_4 : cspwm_pkg::PRE_LIM_1);
	assign pre_tick = running && (pre == pre_lim);
	assign period_end = pre_tick && (q == cspwm_pkg::QUARTER_LAST) && (count == period);

	always_comb begin
		for (int i = 0; i < cspwm_pkg::UNITS; i++) begin
			pwm_on[i] = mode[i][3:2] == cspwm_pkg::MODE_PWM_TOP;
			cmp_event[i] = (TIMEBASE == {high[i], low[i]}) && !eq_prev[i] && !SLEEP
				&& (mode[i][3] || mode[i][3:0] == cspwm_pkg::MODE_TOGGLE) && !pwm_on[i];
		end
	end

	// ---------------------------------------------------------------
	// Next-state logic: timer, units, registers and bus
	// ---------------------------------------------------------------
	always_comb begin
		next_period = period;
		next_tctl = tctl;
		next_alt0 = ALT_SEL0;
		next_alt1 = ALT_SEL1;
		next_pre = pre;
		next_q = q;
		next_count = count;
		if (pre_tick) begin
			next_pre = 4'h0;
			next_q = q + 2'h1;
			if (period_end) begin
				next_count = 8'h00;
			end else if (q == cspwm_pkg::QUARTER_LAST) begin
				next_count = count + 8'h01;
			end
		end else if (running) begin
			next_pre = pre + 4'h1;
		end
		next_flag = (MATCH_FLAG | cmp_event);
		if (wr_en && aw_addr == cspwm_pkg::OFS_FLAGS) begin
			next_flag = (MATCH_FLAG & ~w_data[3:0]) | cmp_event;
		end
		if (wr_en && aw_addr == cspwm_pkg::OFS_PERIOD) begin
			next_period = w_data;
		end else if (wr_en && aw_addr == cspwm_pkg::OFS_TCTL) begin
			next_tctl = w_data & 8'h07;
		end else if (wr_en && aw_addr == cspwm_pkg::OFS_ALT0) begin
			next_alt0 = w_data;
		end else if (wr_en && aw_addr == cspwm_pkg::OFS_ALT1) begin
			next_alt1 = w_data;
		end
		for (int i = 0; i < cspwm_pkg::UNITS; i++) begin
			next_mode[i] = mode[i];
			next_low[i] = low[i];
			next_high[i] = high[i];
			next_latch2[i] = latch2[i];
			next_pin[i] = PIN_OUT[i];
			next_trig[i] = 1'b0;
			next_eq_prev[i] = SLEEP ? eq_prev[i] : (TIMEBASE == {high[i], low[i]});
			if (wr_en && aw_addr[7:6] == cspwm_pkg::UNIT_SPACE && aw_addr[5:4] == i[1:0]) begin
				if (aw_addr[3:0] == cspwm_pkg::OFS_MODE) begin
					next_mode[i] = (i < cspwm_pkg::ENH_UNITS) ? w_data
						: (w_data & ~cspwm_pkg::ENH_MASK);
				end else if (aw_addr[3:0] == cspwm_pkg::OFS_LOW) begin
					next_low[i] = w_data;
				end else if (aw_addr[3:0] == cspwm_pkg::OFS_HIGH && !pwm_on[i]) begin
					next_high[i] = w_data;
				end
			end
			if (pwm_on[i]) begin
				if (period_end) begin
					next_high[i] = low[i];
					next_latch2[i] = mode[i][cspwm_pkg::DUTY_LSB +: 2];
					next_pin[i] = {low[i], mode[i][cspwm_pkg::DUTY_LSB +: 2]} != 10'h000;
				end else if (pre_tick && tb_next == {high[i], latch2[i]}) begin
					next_pin[i] = 1'b0;
				end
			end else if (cmp_event[i]) begin
				case (mode[i][3:0])
					cspwm_pkg::MODE_TOGGLE: next_pin[i] = ~PIN_OUT[i];
					cspwm_pkg::MODE_SET: next_pin[i] = 1'b1;
					cspwm_pkg::MODE_CLEAR: next_pin[i] = 1'b0;
					cspwm_pkg::MODE_TRIG: next_trig[i] = 1'b1;
					default: next_pin[i] = PIN_OUT[i];
				endcase
			end
			if (next_mode[i][3:0] == cspwm_pkg::MODE_OFF) begin
				next_pin[i] = 1'b0;
			end
			next_drive[i] = next_mode[i][3:2] == cspwm_pkg::MODE_PWM_TOP
				|| next_mode[i][3:0] == cspwm_pkg::MODE_TOGGLE
				|| next_mode[i][3:0] == cspwm_pkg::MODE_SET
				|| next_mode[i][3:0] == cspwm_pkg::MODE_CLEAR;
		end
	end

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb0 = w_strb0;
		next_bvalid = S_AXI_BVALID;
		next_bresp = S_AXI_BRESP;
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			next_aw_held = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			next_w_held = 1'b1;
			next_w_data = S_AXI_WDATA[7:0];
			next_w_strb0 = S_AXI_WSTRB[0];
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (aw_addr[1:0] == 2'h0 && ((aw_addr[7:6] == cspwm_pkg::UNIT_SPACE
				&& aw_addr[3:2] != 2'h3) || (aw_addr >= cspwm_pkg::OFS_PERIOD
				&& aw_addr <= cspwm_pkg::OFS_TCOUNT))) ? cspwm_pkg::RESP_OKAY
				: cspwm_pkg::RESP_SLVERR;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		next_rvalid = S_AXI_RVALID;
		next_rdata = S_AXI_RDATA;
		next_rresp = S_AXI_RRESP;
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rdata = 32'h0000_0000;
			next_rresp = cspwm_pkg::RESP_OKAY;
			if (S_AXI_ARADDR[1:0] != 2'h0) begin
				next_rresp = cspwm_pkg::RESP_SLVERR;
			end else if (S_AXI_ARADDR[7:6] == cspwm_pkg::UNIT_SPACE
				&& S_AXI_ARADDR[3:0] == cspwm_pkg::OFS_MODE) begin
				next_rdata[7:0] = mode[S_AXI_ARADDR[5:4]];
			end else if (S_AXI_ARADDR[7:6] == cspwm_pkg::UNIT_SPACE
				&& S_AXI_ARADDR[3:0] == cspwm_pkg::OFS_LOW) begin
				next_rdata[7:0] = low[S_AXI_ARADDR[5:4]];
			end else if (S_AXI_ARADDR[7:6] == cspwm_pkg::UNIT_SPACE
				&& S_AXI_ARADDR[3:0] == cspwm_pkg::OFS_HIGH) begin
				next_rdata[7:0] = high[S_AXI_ARADDR[5:4]];
			end else if (S_AXI_ARADDR == cspwm_pkg::OFS_PERIOD) begin
				next_rdata[7:0] = period;
			end else if (S_AXI_ARADDR == cspwm_pkg::OFS_TCTL) begin
				next_rdata[7:0] = tctl;
			end else if (S_AXI_ARADDR == cspwm_pkg::OFS_ALT0) begin
				next_rdata[7:0] = ALT_SEL0;
			end else if (S_AXI_ARADDR == cspwm_pkg::OFS_ALT1) begin
				next_rdata[7:0] = ALT_SEL1;
			end else if (S_AXI_ARADDR == cspwm_pkg::OFS_FLAGS) begin
				next_rdata[3:0] = MATCH_FLAG;
			end else if (S_AXI_ARADDR == cspwm_pkg::OFS_TCOUNT) begin
				next_rdata[9:0] = tb;
			end else begin
				next_rresp = cspwm_pkg::RESP_SLVERR;
			end
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			next_rvalid = 1'b0;
		end
		next_arready = !next_rvalid;
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < cspwm_pkg::UNITS; i++) begin
				mode[i] <= cspwm_pkg::RST_BYTE;
				low[i] <= cspwm_pkg::RST_BYTE;
				high[i] <= cspwm_pkg::RST_BYTE;
				latch2[i] <= 2'h0;
			end
			eq_prev <= 4'h0;
			period <= cspwm_pkg::RST_PERIOD;
			tctl <= cspwm_pkg::RST_BYTE;
			count <= 8'h00;
			pre <= 4'h0;
			q <= 2'h0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			w_strb0 <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 8'h00;
			PIN_OUT <= 4'h0;
			PIN_DRIVE <= 4'h0;
			TRIGGER <= 4'h0;
			MATCH_FLAG <= 4'h0;
			ALT_SEL0 <= cspwm_pkg::RST_BYTE;
			ALT_SEL1 <= cspwm_pkg::RST_BYTE;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= 2'h0;
		end else begin
			mode <= next_mode;
			low <= next_low;
			high <= next_high;
			latch2 <= next_latch2;
			eq_prev <= next_eq_prev;
			period <= next_period;
			tctl <= next_tctl;
			count <= next_count;
			pre <= next_pre;
			q <= next_q;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			w_strb0 <= next_w_strb0;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			PIN_OUT <= next_pin;
			PIN_DRIVE <= next_drive;
			TRIGGER <= next_trig;
			MATCH_FLAG <= next_flag;
			ALT_SEL0 <= next_alt0;
			ALT_SEL1 <= next_alt1;
			S_AXI_AWREADY <= next_awready;
			S_AXI_WREADY <= next_wready;
			S_AXI_BVALID <= next_bvalid;
			S_AXI_BRESP <= next_bresp;
			S_AXI_ARREADY <= next_arready;
			S_AXI_RVALID <= next_rvalid;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rresp;
		end
	end

	// ---------------------------------------------------------------
	// Checks on units 0 and 1, the shared timer and a read at 8'h20
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	AST_OFF_RELEASE: assert property (mode[0][3:0] == cspwm_pkg::MODE_OFF |->
		!PIN_DRIVE[0] && !PIN_OUT[0]) else $error("unit 0 off but pin still held");
	AST_SLEEP_FREEZE: assert property (SLEEP |=> count == $past(count) && q == $past(q))
		else $error("timer moved during sleep");
	AST_MATCH_FLAG: assert property (cmp_event[0] |=> MATCH_FLAG[0])
		else $error("match did not set flag");
	AST_TRIG_ONE: assert property (TRIGGER[0] |=> !TRIGGER[0] ##1 !TRIGGER[0])
		else $error("trigger longer than one cycle");
	AST_WRAP: assert property (period_end |=> count == 8'h00 && q == 2'h0)
		else $error("count not cleared at period end");
	AST_DUTY_LATCH: assert property (period_end && pwm_on[1] && !wr_en |=>
		high[1] == $past(low[1]) && latch2[1] == $past(mode[1][5:4]))
		else $error("duty not buffered at period end");
	AST_ZERO_DUTY: assert property (period_end && pwm_on[1] && low[1] == 8'h00
		&& mode[1][5:4] == 2'h0 |=> !PIN_OUT[1]) else $error("zero duty raised pin");
	AST_FULL_SET: assert property (period_end && pwm_on[1] && low[1] != 8'h00
		&& !wr_en |=> PIN_OUT[1]) else $error("pin not set at period start");
	AST_DUTY_CLEAR: assert property (pwm_on[1] && pre_tick && !period_end
		&& tb_next == {high[1], latch2[1]} && !wr_en |=> !PIN_OUT[1])
		else $error("pin not cleared at duty match");
	AST_UNIMP_READ: assert property (rd_fire && S_AXI_ARADDR == 8'h20 |=>
		S_AXI_RVALID && S_AXI_RDATA[31:6] == 26'h0) else $error("unimplemented bits read set");
endmodule

// ===== hdl/cspwm_pkg.sv
// Constants shared by the compare and standard pulse-width unit
package cspwm_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int UNITS = 4;
	localparam logic [1:0] UNIT_SPACE = 2'h0;
	localparam logic [3:0] OFS_MODE = 4'h0;
	localparam logic [3:0] OFS_LOW = 4'h4;
	localparam logic [3:0] OFS_HIGH = 4'h8;
	localparam logic [7:0] OFS_PERIOD = 8'h40;
	localparam logic [7:0] OFS_TCTL = 8'h44;
	localparam logic [7:0] OFS_ALT0 = 8'h48;
	localparam logic [7:0] OFS_ALT1 = 8'h4C;
	localparam logic [7:0] OFS_FLAGS = 8'h50;
	localparam logic [7:0] OFS_TCOUNT = 8'h54;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int DUTY_LSB = 4;
	localparam int TCTL_ON_BIT = 2;
	localparam logic [7:0] ENH_MASK = 8'hC0;
	localparam int ENH_UNITS = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hFF;
	// ---------------------------------------------------------------
	// Mode select codes
	// ---------------------------------------------------------------
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_TOGGLE = 4'h2;
	localparam logic [3:0] MODE_SET = 4'h8;
	localparam logic [3:0] MODE_CLEAR = 4'h9;
	localparam logic [3:0] MODE_SWINT = 4'hA;
	localparam logic [3:0] MODE_TRIG = 4'hB;
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;
	// ---------------------------------------------------------------
	// Prescaler limits and bus responses
	// ---------------------------------------------------------------
	localparam logic [3:0] PRE_LIM_1 = 4'h0;
	localparam logic [3:0] PRE_LIM_4 = 4'h3;
	localparam logic [3:0] PRE_LIM_16 = 4'hF;
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== dv/cspwm_load.sv
// Load model on one unit output pin, with pull-down and direction bit
`timescale 1ns/1ps
module cspwm_load (
	input wire logic clk,
	input wire logic pin_out,
	input wire logic pin_drive,
	input wire logic dir_in,
	output logic level,
	output int high_len,
	output int per_len
);
	logic prev = 1'b0;
	int cnt = 0;
	// Waveform reaches the load only with the direction bit clear, else the pull-down wins
	assign level = (pin_drive === 1'b1 && dir_in === 1'b0) ? pin_out : 1'b0;
	// High time and rise-to-rise period in clock cycles
	always @(posedge clk) begin
		prev <= level;
		cnt <= (level && !prev) ? 1 : cnt + 1;
		if (level && !prev)
			per_len <= cnt;
		if (!level && prev)
			high_len <= cnt;
	end
endmodule

// ===== dv/test_compare_and_standard_pwm_unit.sv
// Register-level test of the compare and pulse-width units
`timescale 1ns/1ps
module test_compare_and_standard_pwm_unit;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, alt0, alt1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [15:0] timebase = 16'h0000;
	logic sleep = 1'b0, dir = 1'b1, awready, wready, bvalid, arready, rvalid, level, held;
	logic [1:0] bresp, rresp;
	logic [3:0] pin_out, pin_drive, trigger, match_flag;
	logic [3:0] md [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
	logic dv [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	logic pv [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int high_len, per_len, hi, n_mismatch = 0, n_compared = 0, trig_cnt = 0;

	cspwm_top dut (
		.CLOCK(clock), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .TIMEBASE(timebase), .SLEEP(sleep),
		.PIN_OUT(pin_out), .PIN_DRIVE(pin_drive), .TRIGGER(trigger),
		.MATCH_FLAG(match_flag), .ALT_SEL0(alt0), .ALT_SEL1(alt1)
	);

	cspwm_load load (
		.clk(clock), .pin_out(pin_out[1]), .pin_drive(pin_drive[1]), .dir_in(dir),
		.level(level), .high_len(high_len), .per_len(per_len)
	);

	always #5 clock = ~clock;

	always @(posedge clock) begin
		if (trigger[0] === 1'b1)
			trig_cnt <= trig_cnt + 1;
	end

	// ---------------------------------------------------------------
	// Bus tasks and comparison
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
			input logic [1:0] er = cspwm_pkg::RESP_OKAY);
		@(posedge clock);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] ed,
			input logic [1:0] er = cspwm_pkg::RESP_OKAY);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, {24'h0, ed});
		chk(rresp, er);
	endtask

	function automatic logic [7:0] ua(input int n, input logic [3:0] o);
		return 8'(n * 16) | {4'h0, o};
	endfunction

	task automatic count_high();
		hi = 0;
		repeat (40) begin
			@(posedge clock);
			hi += int'(level);
		end
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#500000;
		n_mismatch++;
		conclude();
	end

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		for (int n = 0; n < 4; n++) begin
			rd(ua(n, cspwm_pkg::OFS_MODE), 8'h00);
			rd(ua(n, cspwm_pkg::OFS_HIGH), 8'h00);
		end
		rd(cspwm_pkg::OFS_PERIOD, 8'hFF);
		rd(cspwm_pkg::OFS_TCTL, 8'h00);
		wr(ua(2, cspwm_pkg::OFS_MODE), 8'hFF);
		rd(ua(2, cspwm_pkg::OFS_MODE), 8'h3F);
		wr(ua(0, cspwm_pkg::OFS_MODE), 8'hC5);
		rd(ua(0, cspwm_pkg::OFS_MODE), 8'hC5);
		wr(cspwm_pkg::OFS_TCTL, 8'hFF);
		rd(cspwm_pkg::OFS_TCTL, 8'h07);
		wr(ua(3, cspwm_pkg::OFS_LOW), 8'hA5);
		wr(ua(3, cspwm_pkg::OFS_HIGH), 8'h5A);
		rd(ua(3, cspwm_pkg::OFS_LOW), 8'hA5);
		rd(ua(3, cspwm_pkg::OFS_HIGH), 8'h5A);
		rd(8'h60, 8'h00, cspwm_pkg::RESP_SLVERR);
		wr(8'h62, 8'h11, cspwm_pkg::RESP_SLVERR);
		wr(cspwm_pkg::OFS_ALT0, 8'h96);
		wr(cspwm_pkg::OFS_ALT1, 8'h69);
		chk(alt0, 8'h96);
		chk(alt1, 8'h69);
		rd(cspwm_pkg::OFS_ALT1, 8'h69);
		wstrb <= 4'hE;
		wr(cspwm_pkg::OFS_ALT0, 8'h11);
		wstrb <= 4'hF;
		rd(cspwm_pkg::OFS_ALT0, 8'h96);
		wr(ua(2, cspwm_pkg::OFS_MODE), 8'h00);
		wr(ua(0, cspwm_pkg::OFS_HIGH), 8'h12);
		wr(ua(0, cspwm_pkg::OFS_LOW), 8'h34);
		// Every compare action on a fresh match of the timebase
		for (int i = 0; i < 5; i++) begin
			wr(ua(0, cspwm_pkg::OFS_MODE), {4'h0, md[i]});
			timebase <= 16'h0000;
			repeat (3) @(posedge clock);
			timebase <= 16'h1234;
			repeat (3) @(posedge clock);
			chk(match_flag[0], 1'b1);
			chk(pin_drive[0], dv[i]);
			if (dv[i])
				chk(pin_out[0], pv[i]);
			wr(cspwm_pkg::OFS_FLAGS, 8'h0F);
			chk(match_flag[0], 1'b0);
		end
		chk(trig_cnt, 1);
		wr(ua(0, cspwm_pkg::OFS_MODE), 8'h00);
		repeat (2) @(posedge clock);
		chk(pin_drive[0], 1'b0);
		// Pulse width on unit one: period 3, duty 6 quarters
		dir <= 1'b0;
		wr(cspwm_pkg::OFS_PERIOD, 8'h03);
		wr(cspwm_pkg::OFS_TCTL, 8'h04);
		wr(ua(1, cspwm_pkg::OFS_LOW), 8'h01);
		wr(ua(1, cspwm_pkg::OFS_MODE), 8'h2C);
		repeat (60) @(posedge clock);
		chk(per_len, 16);
		chk(high_len, 6);
		rd(ua(1, cspwm_pkg::OFS_HIGH), 8'h01);
		wr(ua(1, cspwm_pkg::OFS_HIGH), 8'h55);
		rd(ua(1, cspwm_pkg::OFS_HIGH), 8'h01);
		wr(cspwm_pkg::OFS_TCTL, 8'h05);
		repeat (200) @(posedge clock);
		chk(per_len, 64);
		chk(high_len, 24);
		wr(cspwm_pkg::OFS_TCTL, 8'h06);
		repeat (700) @(posedge clock);
		chk(per_len, 256);
		chk(high_len, 96);
		sleep <= 1'b1;
		repeat (2) @(posedge clock);
		held = pin_out[1];
		repeat (40) @(posedge clock);
		chk(pin_out[1], held);
		chk(pin_drive[1], 1'b1);
		sleep <= 1'b0;
		wr(cspwm_pkg::OFS_TCTL, 8'h04);
		wr(ua(1, cspwm_pkg::OFS_LOW), 8'h00);
		wr(ua(1, cspwm_pkg::OFS_MODE), 8'h0C);
		repeat (40) @(posedge clock);
		count_high();
		chk(hi, 0);
		wr(ua(1, cspwm_pkg::OFS_LOW), 8'hFF);
		wr(ua(1, cspwm_pkg::OFS_MODE), 8'h3C);
		repeat (40) @(posedge clock);
		count_high();
		chk(hi, 40);
		conclude();
	end
endmodule
